// File: design/tat_pkg.sv
// Purpose: Shared constants and types of the timing acquisition core
// Assumes: Clock of 100 MHz, probe inputs synchronous to it
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
package tat_pkg;
   localparam int CH_W = 8;
   localparam int TAG_W = 16;
   localparam int MEM_AW = 10;
   localparam int HALF_AW = 9;
   localparam int HALF_DEPTH = 512;
   localparam int MEM_W = 24;
   localparam int FIFO_DEPTH = 16;
   localparam int REC_W = 1 + CH_W + TAG_W + CH_W;
   localparam int CLK_MHZ = 100;
   localparam int SAMPLE_NS = 10;
   localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ) / 1000;
   localparam int GLITCH_INT_NS = 20;
   localparam int GLITCH_CYC = (GLITCH_INT_NS * CLK_MHZ) / 1000;
   localparam int DIV_W = 2;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h04;
   localparam logic [4:0] OFF_PATTERN = 5'h08;
   localparam logic [4:0] OFF_EDGE = 5'h0c;
   localparam logic [4:0] OFF_POST = 5'h10;
   localparam logic [4:0] OFF_RDADDR = 5'h14;
   localparam logic [4:0] OFF_RDDATA = 5'h18;
   localparam logic [4:0] OFF_TRIG = 5'h1c;
   localparam int CB_RUN = 0;
   localparam int CB_STOP = 1;
   localparam int CB_REP = 2;
   localparam int CB_GLITCH = 3;
   localparam int CB_ARM = 4;
   localparam int CB_STOPEN = 6;
   localparam int FB_CARE = 8;
   localparam logic [MEM_AW-1:0] POST_RST = 10'h3ff;
   localparam logic [TAG_W-1:0] TAG_MAX = 16'hffff;
   typedef enum logic [1:0] {ARM_RUN, ARM_OTHER, ARM_SCOPE, ARM_EXT} tat_arm_t;
   typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_PAT, ST_EDGE, ST_POST, ST_DONE} tat_state_t;
endpackage

// File: design/tat_core.sv
// Purpose: Timing acquisition and two-stage trigger core with register slave
// Assumes: One 100 MHz clock; sys_rst synchronous, active high
// Notes: Probe samples pass a FIFO before the sample memory
// What this block does
// - In single mode one run request yields one acquisition, then the core idles.
// - In repetitive mode acquisitions restart until stop or an enabled stop condition.
// - One trace mode setting is shared with the other analyzer, written from either side.
// - Arming comes from the run command, the other analyzer, the scope or the external input.
// - Transitional mode samples every interval but stores only the first sample and samples that differ.
// - Each stored sample carries a time tag for later reconstruction.
// - Transitional mode samples once every 10 ns regardless of span.
// - Memory fills circularly before the trigger so data up to the trigger is kept.
// - A channel changing more than once within one sample interval is a glitch.
// - A glitch one clock (10 ns) wide is caught only when both its changes fall in one 20 ns interval.
// - Glitch mode can trigger on a glitch and keeps the pre-trigger samples.
// - In glitch mode a per-channel qualifier picks which glitches feed the second stage.
// - The trigger first finds the pattern, then a transition, which is the trigger point.
// - Glitch mode splits memory into sample half and glitch-transition half.
// - The pattern matches only when every channel with its care bit set matches at once.
//
// Chosen here: the register addresses and the Avalon-MM register port.
module tat_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } tat_fifo_state_t;
   tat_fifo_state_t r_reg, r_next;
   logic [W-1:0] mem [D];
   logic doPush, doPop;

   assign inReady = (r_reg.cnt != (AW+1)'(D));
   assign outValid = (r_reg.cnt != '0);
   assign outData = mem[r_reg.rp];
   assign doPush = inValid & inReady;
   assign doPop = outValid & outReady;

   always_comb begin
      r_next = r_reg;
      if (doPush) begin
         r_next.wp = r_reg.wp + 1'b1;
      end
      if (doPop) begin
         r_next.rp = r_reg.rp + 1'b1;
      end
      r_next.cnt = r_reg.cnt + (AW+1)'(doPush) - (AW+1)'(doPop);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[r_reg.wp] <= inData;
      end
   end
endmodule

module tat_core (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Probed channels
   input wire logic [tat_pkg::CH_W-1:0] chIn,
   // Arm sources and stop condition
   input wire logic armOther,
   input wire logic armScope,
   input wire logic armExt,
   input wire logic stopCond,
   // Trace mode shared with the other analyzer
   input wire logic peerModeWr,
   input wire logic peerModeRep,
   output logic traceRepOut,
   // Status
   output logic acqBusy,
   output logic acqDone
);
   import tat_pkg::*;

   typedef struct packed {
      tat_state_t st;
      logic rep;
      logic glitch;
      logic stopEn;
      tat_arm_t arm;
      logic [CH_W-1:0] patVal;
      logic [CH_W-1:0] patCare;
      logic [CH_W-1:0] edgeSel;
      logic [CH_W-1:0] glQual;
      logic [CH_W-1:0] prev;
      logic [CH_W-1:0] prevClk;
      logic [CH_W-1:0] seen;
      logic [CH_W-1:0] gl;
      logic [MEM_AW-1:0] postCnt;
      logic [MEM_AW-1:0] rdAddr;
      logic [MEM_AW-1:0] trigAddr;
      logic [MEM_AW-1:0] wrPtr;
      logic [MEM_AW-1:0] postLeft;
      logic trigWr;
      logic done;
      logic ovf;
      logic ack;
      logic first;
      logic [TAG_W-1:0] tag;
      logic [DIV_W-1:0] div;
      logic [31:0] rdata;
   } tat_core_state_t;

   tat_core_state_t r_reg, r_next;
   logic [MEM_W-1:0] memLo [HALF_DEPTH];
   logic [MEM_W-1:0] memHi [HALF_DEPTH];
   logic sampleEn, acq, patHit, edgeHit, trigNow, storeIt, ctrlWr, armed;
   logic [CH_W-1:0] chg, glNow;
   logic pushValid, pushReady, popValid, popReady, rdBusy;
   logic [REC_W-1:0] pushRec, popRec;
   logic loWe, hiWe;
   logic [HALF_AW-1:0] loA, hiA;
   logic [MEM_W-1:0] loD, hiD, memQ;
   logic [MEM_AW-1:0] nextPtr;

   function automatic logic isAcq(input tat_state_t s);
      return (s == ST_PAT) || (s == ST_EDGE) || (s == ST_POST);
   endfunction

   tat_fifo #(.W(REC_W), .D(FIFO_DEPTH)) sampleFifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(pushRec),
      .outValid(popValid),
      .outReady(popReady),
      .outData(popRec)
   );

   // Drain pauses during memory readout so a read sees a still buffer
   assign rdBusy = read & (address == OFF_RDDATA);
   assign popReady = ~rdBusy;
   assign waitrequest = (read | write) & ~r_reg.ack;
   assign ctrlWr = write & r_reg.ack & (address == OFF_CTRL);
   assign memQ = r_reg.rdAddr[HALF_AW] ? memHi[r_reg.rdAddr[HALF_AW-1:0]]
                                       : memLo[r_reg.rdAddr[HALF_AW-1:0]];
   assign readdata = r_reg.rdata;
   assign traceRepOut = r_reg.rep;
   assign acqBusy = (r_reg.st != ST_IDLE);
   assign acqDone = r_reg.done;

   always_comb begin
      r_next = r_reg;
      sampleEn = r_reg.glitch ? (r_reg.div == DIV_W'(GLITCH_CYC - 1)) : 1'b1;
      acq = isAcq(r_reg.st);
      // Second change within one interval marks a glitch
      chg = chIn ^ r_reg.prevClk;
      glNow = r_reg.gl | (r_reg.seen & chg);
      patHit = ((chIn ^ r_reg.patVal) & r_reg.patCare) == '0;
      edgeHit = (|(chIn & ~r_reg.prev & r_reg.edgeSel)) |
                (r_reg.glitch & (|(glNow & r_reg.glQual)));
      trigNow = (r_reg.st == ST_EDGE) & sampleEn & edgeHit;
      storeIt = acq & sampleEn &
                (r_reg.glitch | r_reg.first | trigNow | (chIn != r_reg.prev));
      pushValid = storeIt;
      pushRec = {trigNow, glNow, r_reg.tag, chIn};
      case (r_reg.arm)
         ARM_RUN: armed = 1'b1;
         ARM_OTHER: armed = armOther;
         ARM_SCOPE: armed = armScope;
         default: armed = armExt;
      endcase
      // Sampling clock domain of the probes
      r_next.prevClk = chIn;
      r_next.div = sampleEn ? '0 : r_reg.div + 1'b1;
      r_next.seen = sampleEn ? '0 : (r_reg.seen | chg);
      r_next.gl = sampleEn ? '0 : glNow;
      if (acq & sampleEn) begin
         r_next.prev = chIn;
         r_next.first = 1'b0;
         if (storeIt) begin
            r_next.tag = TAG_W'(SAMPLE_CYC);
         end else if (r_reg.tag != TAG_MAX) begin
            r_next.tag = r_reg.tag + 1'b1;
         end
      end
      if (storeIt & ~pushReady) begin
         r_next.ovf = 1'b1;
      end
      // Memory writer
      loWe = 1'b0;
      hiWe = 1'b0;
      loA = r_reg.wrPtr[HALF_AW-1:0];
      hiA = r_reg.wrPtr[HALF_AW-1:0];
      loD = popRec[MEM_W-1:0];
      hiD = r_reg.glitch ? MEM_W'(popRec[MEM_W +: CH_W]) : popRec[MEM_W-1:0];
      nextPtr = r_reg.wrPtr + 1'b1;
      if (r_reg.glitch) begin
         nextPtr[HALF_AW] = 1'b0;
      end
      if (popValid & popReady & acq) begin
         // Circular fill before the trigger keeps the newest prestore data
         r_next.wrPtr = nextPtr;
         if (r_reg.glitch) begin
            loWe = 1'b1;
            hiWe = 1'b1;
         end else begin
            loWe = ~r_reg.wrPtr[HALF_AW];
            hiWe = r_reg.wrPtr[HALF_AW];
         end
         if (popRec[REC_W-1]) begin
            r_next.trigWr = 1'b1;
            r_next.trigAddr = r_reg.wrPtr;
            r_next.postLeft = r_reg.postCnt;
            if (r_reg.postCnt == '0) begin
               r_next.st = ST_DONE;
            end
         end else if (r_reg.trigWr) begin
            r_next.postLeft = r_reg.postLeft - 1'b1;
            if (r_reg.postLeft == MEM_AW'(1)) begin
               r_next.st = ST_DONE;
            end
         end
      end
      // Trigger sequencer
      case (r_reg.st)
         ST_IDLE: ;
         ST_ARM: begin
            if (armed) begin
               r_next.st = ST_PAT;
               r_next.first = 1'b1;
               r_next.tag = '0;
               r_next.trigWr = 1'b0;
               r_next.wrPtr = '0;
            end
         end
         ST_PAT: begin
            if (sampleEn & patHit) begin
               r_next.st = ST_EDGE;
            end
         end
         ST_EDGE: begin
            if (trigNow) begin
               r_next.st = ST_POST;
            end
         end
         ST_POST: ;
         ST_DONE: begin
            r_next.done = 1'b1;
            if (r_reg.rep & ~(r_reg.stopEn & stopCond)) begin
               r_next.st = ST_ARM;
            end else begin
               r_next.st = ST_IDLE;
            end
         end
         default: r_next.st = ST_IDLE;
      endcase
      // Register slave: one wait cycle, then the answer
      r_next.ack = (read | write) & ~r_reg.ack;
      if (read & ~r_reg.ack) begin
         case (address)
            OFF_CTRL: r_next.rdata = {25'h0, r_reg.stopEn, r_reg.arm, r_reg.glitch,
                                      r_reg.rep, 2'h0};
            OFF_STATUS: r_next.rdata = {27'h0, r_reg.ovf, r_reg.done, r_reg.st};
            OFF_PATTERN: r_next.rdata = {16'h0, r_reg.patCare, r_reg.patVal};
            OFF_EDGE: r_next.rdata = {16'h0, r_reg.glQual, r_reg.edgeSel};
            OFF_POST: r_next.rdata = 32'(r_reg.postCnt);
            OFF_RDADDR: r_next.rdata = 32'(r_reg.rdAddr);
            OFF_RDDATA: r_next.rdata = 32'(memQ);
            OFF_TRIG: r_next.rdata = 32'(r_reg.trigAddr);
            default: r_next.rdata = '0;
         endcase
      end
      if (peerModeWr) begin
         r_next.rep = peerModeRep;
      end
      if (write & r_reg.ack) begin
         case (address)
            OFF_CTRL: begin
               r_next.rep = writedata[CB_REP];
               r_next.glitch = writedata[CB_GLITCH];
               r_next.arm = tat_arm_t'(writedata[CB_ARM +: 2]);
               r_next.stopEn = writedata[CB_STOPEN];
               if (writedata[CB_STOP]) begin
                  r_next.st = ST_IDLE;
               end else if (writedata[CB_RUN]) begin
                  r_next.st = ST_ARM;
                  r_next.done = 1'b0;
                  // A drop in the same cycle as the run still reports overflow
                  r_next.ovf = storeIt & ~pushReady;
               end
            end
            OFF_PATTERN: begin
               r_next.patVal = writedata[CH_W-1:0];
               r_next.patCare = writedata[FB_CARE +: CH_W];
            end
            OFF_EDGE: begin
               r_next.edgeSel = writedata[CH_W-1:0];
               r_next.glQual = writedata[FB_CARE +: CH_W];
            end
            OFF_POST: r_next.postCnt = writedata[MEM_AW-1:0];
            OFF_RDADDR: r_next.rdAddr = writedata[MEM_AW-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
         r_reg.postCnt <= POST_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   always_ff @(posedge clk) begin
      if (loWe) begin
         memLo[loA] <= loD;
      end
      if (hiWe) begin
         memHi[hiA] <= hiD;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence sPatHit;
      r_reg.st == ST_PAT && sampleEn && patHit && !ctrlWr && !(write && r_reg.ack);
   endsequence
   sequence sEdgeHit;
      r_reg.st == ST_EDGE && trigNow && !(write && r_reg.ack);
   endsequence

   a_single_stops: assert property (
      r_reg.st == ST_DONE && !r_reg.rep && !ctrlWr |=> r_reg.st == ST_IDLE && acqDone)
      else $error("single trace did not stop");
   a_repeat_rearm: assert property (
      r_reg.st == ST_DONE && r_reg.rep && !(r_reg.stopEn && stopCond) && !ctrlWr
      |=> r_reg.st == ST_ARM)
      else $error("repetitive trace did not rearm");
   a_mode_shared: assert property (
      peerModeWr && !ctrlWr |=> traceRepOut == $past(peerModeRep))
      else $error("peer trace mode not taken");
   a_run_arms: assert property (
      r_reg.st == ST_ARM && r_reg.arm == ARM_RUN && !ctrlWr |=> r_reg.st == ST_PAT)
      else $error("run arm did not start acquisition");
   a_trans_store: assert property (
      pushValid && !r_reg.glitch |-> r_reg.first || trigNow || chIn != r_reg.prev)
      else $error("unchanged sample stored");
   a_fixed_rate: assert property (
      !r_reg.glitch |-> sampleEn)
      else $error("transitional sample skipped");
   a_tag_count: assert property (
      acq && sampleEn && !storeIt && r_reg.tag != TAG_MAX && !ctrlWr
      ##1 isAcq(r_reg.st) |-> r_reg.tag == $past(r_reg.tag) + 1'b1)
      else $error("time tag did not advance");
   a_two_stage: assert property (
      sPatHit ##1 sEdgeHit |=> r_reg.st == ST_POST || r_reg.st == ST_DONE)
      else $error("pattern then edge did not trigger");
   a_pattern_and: assert property (
      sPatHit |=> r_reg.st == ST_EDGE || r_reg.st == ST_DONE)
      else $error("pattern match not taken");
   a_glitch_half: assert property (
      loWe && r_reg.glitch |-> hiWe && hiA == loA && r_next.wrPtr[HALF_AW] == 1'b0)
      else $error("glitch half not written beside sample");
endmodule

// File: verification/tat_probe_model.sv
// Purpose: Probed signals of the system under test
// Assumes: Every change lands just after a rising clock edge
// Notes: Steady level, channels toggling every four clocks, one-clock pulses
module tat_probe_model (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Stimulus from the bench
   input wire logic [tat_pkg::CH_W-1:0] baseVal,
   input wire logic [tat_pkg::CH_W-1:0] toggleMask,
   input wire logic [tat_pkg::CH_W-1:0] pulseMask,
   // Probed channels
   output logic [tat_pkg::CH_W-1:0] chIn
);
   import tat_pkg::*;
   logic [2:0] cycReg;
   always_ff @(posedge clk) begin
      cycReg <= sys_rst ? 3'h0 : cycReg + 3'h1;
      chIn <= baseVal ^ (cycReg[2] ? toggleMask : '0) ^ pulseMask;
   end
endmodule

// File: verification/tb_top.sv
// Purpose: Self-checking bench of the timing acquisition core
// Assumes: 100 MHz clock, synchronous active-high reset held 16 cycles
// Notes: Register cases run from a table; acquisitions are hand-written
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tat_pkg::*;
   typedef struct packed {
      logic [4:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic r;
   } tat_row_t;
   localparam tat_row_t ROWS [0:8] = '{
      '{OFF_CTRL, 32'h00000000, 32'h00000000, 1'b0},
      '{OFF_CTRL, 32'h00000014, 32'h00000014, 1'b1},
      '{OFF_CTRL, 32'h00000028, 32'h00000028, 1'b0},
      '{OFF_CTRL, 32'h0000007c, 32'h0000007c, 1'b1},
      '{OFF_PATTERN, 32'hffffffff, 32'h0000ffff, 1'b1},
      '{OFF_EDGE, 32'hffff1234, 32'h00001234, 1'b1},
      '{OFF_POST, 32'hffffffff, 32'h000003ff, 1'b1},
      '{OFF_POST, 32'h00000005, 32'h00000005, 1'b1},
      '{OFF_STATUS, 32'hffffffff, 32'h00000000, 1'b1}};
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   logic [CH_W-1:0] chIn;
   logic [CH_W-1:0] baseVal = 8'h00;
   logic [CH_W-1:0] toggleMask = 8'h00;
   logic [CH_W-1:0] pulseMask = 8'h00;
   logic armOther = 1'b0;
   logic armScope = 1'b0;
   logic armExt = 1'b0;
   logic stopCond = 1'b0;
   logic peerModeWr = 1'b0;
   logic peerModeRep = 1'b0;
   logic traceRepOut;
   logic acqBusy;
   logic acqDone;
   logic [31:0] rd;
   logic [MEM_AW-1:0] trigIdx;
   logic [31:0] expRec [0:4] = '{32'h01, 32'h000603, 32'h000507, 32'h00070f, 32'h00031f};
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;

   tat_core tat_core_i (.clk(clk), .sys_rst(sysRst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .chIn(chIn), .armOther(armOther), .armScope(armScope), .armExt(armExt),
      .stopCond(stopCond), .peerModeWr(peerModeWr), .peerModeRep(peerModeRep),
      .traceRepOut(traceRepOut), .acqBusy(acqBusy), .acqDone(acqDone));
   tat_probe_model tat_probe_model_i (.clk(clk), .sys_rst(sysRst), .baseVal(baseVal),
      .toggleMask(toggleMask), .pulseMask(pulseMask), .chIn(chIn));

   always #5 clk = ~clk;

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("[ERR] %0t run did not finish", $time);
         wrap_up();
      end
   end

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
      end
   endtask

   // One bus cycle; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk32(rd & m, e);
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic waitIdle();
      int n;
      for (n = 0; n < 500 && acqBusy !== 1'b0; n++) @(posedge clk);
   endtask

   task automatic pulse(input logic [CH_W-1:0] m);
      @(posedge clk);
      pulseMask <= m;
      @(posedge clk);
      pulseMask <= 8'h00;
   endtask

   initial begin
      step(16);
      sysRst <= 1'b0;
      step(1);
      chkBit(traceRepOut, 1'b0);
      chkBit(acqBusy, 1'b0);
      chkBit(acqDone, 1'b0);
      rdc(OFF_POST, 32'hffffffff, 32'h3ff);
      rdc(OFF_STATUS, 32'hffffffff, 32'h0);
      foreach (ROWS[i]) begin
         bus(1'b1, ROWS[i].a, ROWS[i].d);
         rdc(ROWS[i].a, 32'hffffffff, ROWS[i].e);
         chkBit(traceRepOut, ROWS[i].r);
      end
      // Trace mode written by the other analyzer
      bus(1'b1, OFF_CTRL, 32'h0);
      peerModeRep <= 1'b1;
      peerModeWr <= 1'b1;
      step(1);
      peerModeWr <= 1'b0;
      step(1);
      chkBit(traceRepOut, 1'b1);
      rdc(OFF_CTRL, 32'h4, 32'h4);
      bus(1'b1, OFF_CTRL, 32'h0);
      step(1);
      chkBit(traceRepOut, 1'b0);
      // Single transitional run: pattern on ch0, rise of ch1, three records after
      bus(1'b1, OFF_PATTERN, 32'h0101);
      bus(1'b1, OFF_EDGE, 32'h0002);
      bus(1'b1, OFF_POST, 32'h3);
      bus(1'b1, OFF_CTRL, 32'h1);
      step(8);
      baseVal <= 8'h01;
      step(6);
      baseVal <= 8'h03;
      step(5);
      baseVal <= 8'h07;
      step(7);
      baseVal <= 8'h0f;
      step(3);
      baseVal <= 8'h1f;
      waitIdle();
      chkBit(acqDone, 1'b1);
      chkBit(acqBusy, 1'b0);
      bus(1'b0, OFF_TRIG, 32'h0);
      trigIdx = rd[MEM_AW-1:0];
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, OFF_RDADDR, 32'(trigIdx + MEM_AW'(k) - 10'h1));
         rdc(OFF_RDDATA, k == 0 ? 32'hff : 32'hffffff, expRec[k]);
      end
      // Repetitive run ended by the stop condition, then by the stop command
      bus(1'b1, OFF_PATTERN, 32'h0);
      bus(1'b1, OFF_EDGE, 32'h1);
      bus(1'b1, OFF_POST, 32'h2);
      toggleMask <= 8'h01;
      bus(1'b1, OFF_CTRL, 32'h45);
      step(1);
      chkBit(acqDone, 1'b0);
      while (acqDone !== 1'b1) @(posedge clk);
      step(3);
      chkBit(acqBusy, 1'b1);
      stopCond <= 1'b1;
      waitIdle();
      chkBit(acqBusy, 1'b0);
      stopCond <= 1'b0;
      bus(1'b1, OFF_CTRL, 32'h45);
      step(100);
      chkBit(acqBusy, 1'b1);
      bus(1'b1, OFF_CTRL, 32'h06);
      waitIdle();
      chkBit(acqBusy, 1'b0);
      toggleMask <= 8'h00;
      // Other, scope and external arm sources; partial pattern holds, full pattern advances
      bus(1'b1, OFF_PATTERN, 32'h0303);
      baseVal <= 8'h01;
      for (int s = 1; s < 4; s++) begin
         bus(1'b1, OFF_CTRL, 32'(s * 16 + 1));
         step(4);
         rdc(OFF_STATUS, 32'h7, 32'h1);
         {armExt, armScope, armOther} <= 3'(1 << (s - 1));
         step(4);
         rdc(OFF_STATUS, 32'h7, 32'h2);
         baseVal <= 8'h03;
         step(4);
         rdc(OFF_STATUS, 32'h7, 32'h3);
         {armExt, armScope, armOther} <= 3'b000;
         baseVal <= 8'h01;
         bus(1'b1, OFF_CTRL, 32'h2);
         waitIdle();
      end
      // Glitch run: unqualified glitch ignored, qualified glitch triggers
      baseVal <= 8'h00;
      bus(1'b1, OFF_PATTERN, 32'h0);
      bus(1'b1, OFF_EDGE, 32'h0400);
      bus(1'b1, OFF_CTRL, 32'h09);
      step(8);
      pulse(8'h08);
      step(1);
      pulse(8'h08);
      step(4);
      rdc(OFF_STATUS, 32'h7, 32'h3);
      pulse(8'h04);
      step(1);
      pulse(8'h04);
      waitIdle();
      chkBit(acqDone, 1'b1);
      bus(1'b0, OFF_TRIG, 32'h0);
      trigIdx = rd[MEM_AW-1:0];
      bus(1'b1, OFF_RDADDR, {22'h0, 1'b1, trigIdx[HALF_AW-1:0]});
      rdc(OFF_RDDATA, 32'h4, 32'h4);
      bus(1'b1, OFF_RDADDR, {22'h0, 1'b0, trigIdx[HALF_AW-1:0] - 9'h1});
      rdc(OFF_RDDATA, 32'hff, 32'h0);
      wrap_up();
   end
endmodule
